// ---- verilog/cst_consts.svh ----
// cst_consts.svh: offsets, field positions, reset values and timing counts
// assumes a register port with 12-bit byte addresses and 8-bit data
`ifndef CST_CONSTS_SVH
`define CST_CONSTS_SVH
`define CST_ADDR_STAT        12'h05b
`define CST_ADDR_TUNE        12'h066
`define CST_TUNE_RESET       8'h02
`define CST_STAT_RSVD        8'h08
`define CST_BIT_HALTED       1
`define CST_BIT_FIRST_DONE   0
`define CST_BIT_TIMING_AUTO  0
`define CST_PASS_CYCLES      16'd64
`define CST_TIMING_CYCLES    16'd32
`endif

// ---- verilog/cst_pkg.sv ----
// cst_pkg.sv: types shared by the calibration status block
// assumes cst_consts.svh for the numbers
package cst_pkg;
  typedef enum logic [1:0] {
    CST_IDLE,
    CST_FORE,
    CST_TIMING,
    CST_BACK
  } cst_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } cst_req_t;
endpackage : cst_pkg

// ---- verilog/cst_pass_timer.sv ----
// cst_pass_timer.sv: counts out one calibration pass
// assumes start is a one-cycle pulse on sys_clk
`timescale 1ns/1ns
`default_nettype none
module cst_pass_timer #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // control
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] length,
  output var  logic             done
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic             done_next;
  logic             done_reg;

  // a one-bit counter cannot tell a live pass from its last cycle
  if (WIDTH < 2) begin : g_bad_width
    $error("cst_pass_timer: WIDTH too small");
  end

  always_comb begin
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    if (start) begin
      cnt_next = (length == '0) ? WIDTH'(1) : length;
    end else if (cnt_reg != '0) begin
      cnt_next  = cnt_reg - WIDTH'(1);
      done_next = (cnt_reg == WIDTH'(1));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;
endmodule : cst_pass_timer
`default_nettype wire

// ---- verilog/cst_calib_status.sv ----
// cst_calib_status.sv: calibration status readback and timing tune control
// assumes a serial-port front end delivering single-cycle register requests
// assumes run and trigger levels come from neighbouring registers on sys_clk
// assumes the trigger owner clears its bit when trigger_clear is high
`timescale 1ns/1ns
`default_nettype none
`include "cst_consts.svh"
module cst_calib_status
  import cst_pkg::*;
#(
  parameter int          TIMER_W        = 16,
  parameter [TIMER_W-1:0] PASS_CYCLES   = `CST_PASS_CYCLES,
  parameter [TIMER_W-1:0] TIMING_CYCLES = `CST_TIMING_CYCLES
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // register port
  input  wire cst_req_t   req,
  output var  logic [7:0] rdata,
  // calibration controls from neighbouring registers
  input  wire logic       continuous_calibration_run,
  input  wire logic       software_calibration_trigger,
  output var  logic       trigger_clear,
  // status toward the converter core
  output var  logic       converter_ready,
  output var  logic       timing_auto_en,
  output var  logic       timing_pass_active
);
  // engine state group
  cst_state_t         state_reg;
  cst_state_t         state_next;
  logic               first_done_reg;
  logic               first_done_next;
  logic               halted_reg;
  logic               halted_next;
  logic               timing_active_reg;
  logic               timing_active_next;

  // register group
  logic [7:0]         tune_reg;
  logic [7:0]         tune_next;
  logic [7:0]         status_word;
  logic [7:0]         rdata_reg;
  logic [7:0]         rdata_next;

  // address decode
  logic               stat_hit;
  logic               tune_hit;

  // pass timer handshake
  logic               timer_start;
  logic [TIMER_W-1:0] timer_len;
  logic               timer_done;

  // refuse widths and lengths the timer cannot count
  if (TIMER_W < 2) begin : g_bad_width
    $error("cst_calib_status: TIMER_W below 2");
  end
  if (PASS_CYCLES == '0) begin : g_bad_pass
    $error("cst_calib_status: PASS_CYCLES is zero");
  end
  if (TIMING_CYCLES == '0) begin : g_bad_timing
    $error("cst_calib_status: TIMING_CYCLES is zero");
  end

  // one timer serves every pass; passes never overlap
  cst_pass_timer #(.WIDTH(TIMER_W)) u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (timer_start),
    .length  (timer_len),
    .done    (timer_done)
  );

  always_comb begin
    state_next      = state_reg;
    first_done_next = first_done_reg;
    timer_start     = 1'b0;
    // trigger restarts the engine
    // a trigger wins over every state so no restart is lost
    if (software_calibration_trigger) begin
      state_next  = CST_FORE;
      timer_start = 1'b1;
    end else begin
      case (state_reg)
        CST_IDLE: begin
          if (continuous_calibration_run) begin
            state_next  = CST_BACK;
            timer_start = 1'b1;
          end
        end
        CST_FORE: begin
          if (timer_done) begin
            first_done_next = 1'b1;
            if (tune_reg[`CST_BIT_TIMING_AUTO]) begin
              state_next  = CST_TIMING;
              timer_start = 1'b1;
            end else begin
              state_next = CST_IDLE;
            end
          end
        end
        CST_TIMING: begin
          if (timer_done) begin
            state_next = CST_IDLE;
          end
        end
        CST_BACK: begin
          // finish current pass before halting
          // run dropping mid-pass only stops the next pass
          if (timer_done) begin
            if (continuous_calibration_run) begin
              timer_start = 1'b1;
            end else begin
              state_next = CST_IDLE;
            end
          end
        end
        default: state_next = CST_IDLE;
      endcase
    end
    // flags registered so status and outputs come from flops
    halted_next        = (state_next == CST_IDLE);
    timing_active_next = (state_next == CST_TIMING);
  end

  // pass length follows the state being entered
  always_comb begin
    timer_len = PASS_CYCLES;
    if (state_next == CST_TIMING) begin
      timer_len = TIMING_CYCLES;
    end
  end

  // address decode shared by reads and writes
  always_comb begin
    stat_hit = 1'b0;
    tune_hit = 1'b0;
    if (req.addr == `CST_ADDR_STAT) begin
      stat_hit = 1'b1;
    end else if (req.addr == `CST_ADDR_TUNE) begin
      tune_hit = 1'b1;
    end
  end

  // writes to the status address fall through and are ignored
  always_comb begin
    tune_next = tune_reg;
    // writable tune register
    // reserved tune bits are kept as written
    if (req.wr && tune_hit) begin
      tune_next = req.wdata;
    end
  end

  // reserved field fixed, flags from their flops
  always_comb begin
    status_word = `CST_STAT_RSVD;
    status_word[`CST_BIT_HALTED] = halted_reg;
    status_word[`CST_BIT_FIRST_DONE] = first_done_reg;
  end

  // read data holds until the next read
  always_comb begin
    rdata_next = rdata_reg;
    if (req.rd) begin
      if (stat_hit) begin
        rdata_next = status_word;
      end else if (tune_hit) begin
        rdata_next = tune_reg;
      end else begin
        // unmapped reads return zero
        rdata_next = 8'h00;
      end
    end
  end

  // engine state and its registered flags
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg         <= CST_IDLE;
      first_done_reg    <= 1'b0;
      halted_reg        <= 1'b1;
      timing_active_reg <= 1'b0;
    end else begin
      state_reg         <= state_next;
      first_done_reg    <= first_done_next;
      halted_reg        <= halted_next;
      timing_active_reg <= timing_active_next;
    end
  end

  // tune register keeps its reset pattern until written
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tune_reg <= `CST_TUNE_RESET;
    end else begin
      tune_reg <= tune_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // self-clear pulse back to the trigger bit's owner
  assign trigger_clear      = software_calibration_trigger;
  assign rdata              = rdata_reg;
  assign converter_ready    = first_done_reg;
  assign timing_auto_en     = tune_reg[`CST_BIT_TIMING_AUTO];
  assign timing_pass_active = timing_active_reg;
endmodule : cst_calib_status
`default_nettype wire

// ---- bench/cst_calib_status_chk.sv ----
// cst_calib_status_chk.sv: port assertions for the calibration status block
// assumes one sys_clk domain with synchronous active-high rst
`timescale 1ns/1ns
`default_nettype none
module cst_calib_status_chk
  import cst_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // register port and controls
  input wire cst_req_t   req,
  input wire logic [7:0] rdata,
  input wire logic       continuous_calibration_run,
  input wire logic       software_calibration_trigger,
  // status
  input wire logic       trigger_clear,
  input wire logic       converter_ready,
  input wire logic       timing_auto_en,
  input wire logic       timing_pass_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence stat_rd;
    req.rd && req.addr == 12'h05b;
  endsequence
  // one-cycle run request from idle starts a pass that outlives the clear
  sequence run_drop;
    $rose(continuous_calibration_run) ##1 $fell(continuous_calibration_run);
  endsequence
  trig_self_clear_a: assert property (software_calibration_trigger |-> trigger_clear)
    else $error("trigger not cleared");
  ready_sticky_a: assert property (converter_ready |=> converter_ready)
    else $error("ready dropped");
  tune_write_a: assert property (req.wr && req.addr == 12'h066 |=> timing_auto_en == $past(req.wdata[0]))
    else $error("tune bit not taken");
  tune_read_a: assert property (req.rd && req.addr == 12'h066 |=> rdata == {7'h01, $past(timing_auto_en)})
    else $error("tune readback wrong");
  timing_gate_a: assert property ($rose(timing_pass_active) |-> timing_auto_en)
    else $error("timing pass without enable");
  fore_busy_a: assert property (software_calibration_trigger ##1 stat_rd |=> !rdata[1])
    else $error("halted during pass");
  drop_busy_a: assert property (run_drop ##1 stat_rd |=> !rdata[1])
    else $error("halted at run clear");
  stat_read_a: assert property (stat_rd |=> rdata[7:2] == 6'h02 && rdata[0] == $past(converter_ready))
    else $error("status readback wrong");
endmodule : cst_calib_status_chk
bind cst_calib_status cst_calib_status_chk u_chk (
  .sys_clk                      (sys_clk),
  .rst                          (rst),
  .req                          (req),
  .rdata                        (rdata),
  .continuous_calibration_run   (continuous_calibration_run),
  .software_calibration_trigger (software_calibration_trigger),
  .trigger_clear                (trigger_clear),
  .converter_ready              (converter_ready),
  .timing_auto_en               (timing_auto_en),
  .timing_pass_active           (timing_pass_active)
);
`default_nettype wire

// ---- bench/cst_calib_status_bench.sv ----
// cst_calib_status_bench.sv: register-level tests of the calibration status block
// assumes the checker is bound from its own file
`timescale 1ns/1ns
`default_nettype none
module cst_calib_status_bench
  import cst_pkg::*;
();
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       run = 1'b0;
  logic       trig = 1'b0;
  cst_req_t   req = '0;
  logic [7:0] rdata;
  logic       clr, rdy, aen, tact;
  int         err_count = 0;
  int         checks_done = 0;
  always #20 sys_clk = ~sys_clk;
  // short passes keep the run brief
  cst_calib_status #(.PASS_CYCLES(16'd4), .TIMING_CYCLES(16'd4)) u_cst_calib_status (
    .sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata), .continuous_calibration_run(run),
    .software_calibration_trigger(trig), .trigger_clear(clr), .converter_ready(rdy),
    .timing_auto_en(aen), .timing_pass_active(tact));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // idle cycle after each access avoids double drive
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge sys_clk);
    req <= '0;
    @(negedge sys_clk);
  endtask : acc
  task automatic poll(input logic [7:0] e);
    for (int i = 0; i < 40 && rdata !== e; i++) acc(1'b0, 12'h05b, 8'h00);
    chk(rdata, e);
  endtask : poll
  task automatic finish_test();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    acc(1'b0, 12'h066, 8'h00);
    chk(rdata, 8'h02);
    acc(1'b1, 12'h05b, 8'hff);
    acc(1'b0, 12'h05b, 8'h00);
    chk(rdata, 8'h0a);
    acc(1'b0, 12'h100, 8'h00);
    chk(rdata, 8'h00);
    acc(1'b1, 12'h066, 8'h03);
    chk({7'h0, aen}, 8'h01);
    repeat (3) @(negedge sys_clk);
    chk({7'h0, tact}, 8'h00);
    trig <= 1'b1;
    #1 chk({7'h0, clr}, 8'h01);
    @(negedge sys_clk);
    trig <= 1'b0;
    acc(1'b0, 12'h05b, 8'h00);
    chk(rdata, 8'h08);
    for (int i = 0; i < 20 && tact !== 1'b1; i++) @(negedge sys_clk);
    chk({7'h0, tact}, 8'h01);
    poll(8'h0b);
    // one-cycle run request; its pass must outlive the clear
    run <= 1'b1;
    @(negedge sys_clk);
    run <= 1'b0;
    @(negedge sys_clk);
    acc(1'b0, 12'h05b, 8'h00);
    chk(rdata, 8'h09);
    acc(1'b0, 12'h05b, 8'h00);
    chk(rdata, 8'h09);
    poll(8'h0b);
    acc(1'b1, 12'h066, 8'h02);
    chk({7'h0, aen}, 8'h00);
    chk({7'h0, rdy}, 8'h01);
    finish_test();
  end
endmodule : cst_calib_status_bench
`default_nettype wire
